// >>> atos_pkg.sv
// Package for the auxiliary test output select block: register map, codes, resets.
// Assumes a 32-bit AHB-Lite register bus; offsets are indices, byte address is four times.
package atos_pkg;
  localparam int unsigned ADDR_W = 10;
  // Printed offsets are not word multiples, so they are register indices
  localparam logic [7:0] IDX_SRC_SEL   = 8'h38;
  localparam logic [7:0] IDX_LEVEL_ONE = 8'h39;
  localparam logic [7:0] IDX_LEVEL_TWO = 8'h3A;
  localparam logic [7:0] IDX_IQ_READ   = 8'h3B;
  localparam logic [7:0] IDX_FACT_A    = 8'h3C;
  localparam logic [7:0] IDX_FACT_B    = 8'h3D;
  localparam logic [7:0] IDX_FACT_C    = 8'h3E;
  localparam logic [7:0] IDX_FACT_D    = 8'h3F;
  localparam logic [7:0] IDX_OBS_SEL   = 8'h40;
  localparam logic [7:0] RST_SRC_SEL   = 8'h00;
  localparam logic [7:0] RST_FACT_A    = 8'hFF;
  localparam logic [7:0] RST_FACT_B    = 8'h00;
  localparam logic [7:0] RST_FACT_C    = 8'h03;
  localparam logic [7:0] RST_FACT_D    = 8'h00;
  localparam logic [5:0] RST_LEVEL     = 6'h00;
  localparam logic [2:0] RST_OBS_SEL   = 3'h0;
  localparam int unsigned SEL1_LSB = 4;
  localparam int unsigned SEL2_LSB = 0;
  localparam int unsigned IQ_I_LSB = 4;
  localparam logic [4:0] SRC_TRISTATE  = 5'h00;
  localparam logic [3:0] SRC_HIZ       = 4'h0;
  localparam logic [3:0] SRC_LEVEL     = 4'h1;
  localparam logic [3:0] SRC_CORR_ONE  = 4'h2;
  localparam logic [3:0] SRC_MIN_LEVEL = 4'h4;
  localparam logic [3:0] SRC_ADC_I     = 4'h5;
  localparam logic [3:0] SRC_ADC_Q     = 4'h6;
  localparam logic [3:0] SRC_PROD      = 4'h8;
  localparam logic [3:0] SRC_HIGH      = 4'hA;
  localparam logic [3:0] SRC_LOW       = 4'hB;
  localparam logic [3:0] SRC_TX_ACT    = 4'hC;
  localparam logic [3:0] SRC_RX_ACT    = 4'hD;
  localparam logic [3:0] SRC_SUBC      = 4'hE;
  localparam logic [3:0] SRC_TEST_BIT  = 4'hF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;
  typedef enum logic [1:0] {
    ATOS_KIND_HIZ,
    ATOS_KIND_DIGITAL,
    ATOS_KIND_ANALOG
  } atos_kind_t;
endpackage

// >>> atos_top.sv
// Auxiliary test output select: two observe pins, test levels, I/Q readback, factory slots.
// Assumes a single AHB-Lite master, synchronous inputs and the analogue cells outside.
//
// Function
// RQ1 - Source select register at 38h resets to zero; both pins high impedance.
// RQ2 - Bits 7:4 pick the first pin source; 0000 means high impedance.
// RQ3 - Code 0001 routes level one to first pin, level two to second.
// RQ4 - Code 0010 gives correlator signal, 0100 gives minimum level signal.
// RQ5 - Codes 0101 and 0110 give in-phase and quadrature samples.
// RQ6 - Codes 0011, 0111, 1001 do nothing; 1000 carries production test signal.
// RQ7 - Code 1010 drives high, 1011 drives low.
// RQ8 - Code 1100 drives the transmit activity flag.
// RQ9 - Code 1101 drives the receive activity flag.
// RQ10 - Code 1110 drives subcarrier detected flag; meaningless at 106 kBd.
// RQ11 - Code 1111 drives one test bus bit picked by a 3-bit select.
// RQ12 - Bits 3:0 pick the second pin source with the same table.
// RQ13 - Level one register holds six writable bits; upper bits reserved.
// RQ14 - Level two register holds six writable bits; upper bits reserved.
// RQ15 - Read-only I/Q readback: in-phase in 7:4, quadrature in 3:0.
// RQ16 - Four factory slots at top; first resets to all ones.
// RQ17 - Slot at 3Eh resets to 03h, the other two to zero.
// RQ18 - Writes to reserved bits or slots are ignored; reads return reset contents.
`timescale 1ns/1ps
module atos_top #(
  parameter int unsigned LEVEL_W = 6,
  parameter int unsigned SAMPLE_W = 4
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic      [1:0]          hresp,
  input  wire logic                i_correlator_one_signal,
  input  wire logic                i_minimum_level_signal,
  input  wire logic                i_production_test_signal,
  input  wire logic                i_transmit_activity_flag,
  input  wire logic                i_receive_activity_flag,
  input  wire logic                i_subcarrier_flag,
  input  wire logic [7:0]          i_test_bus,
  input  wire logic [SAMPLE_W-1:0] i_adc_i_sample,
  input  wire logic [SAMPLE_W-1:0] i_adc_q_sample,
  output logic                     o_first_observe_pin,
  output logic                     o_first_observe_pin_oe_n,
  output logic      [1:0]          o_first_observe_kind,
  output logic      [SAMPLE_W+LEVEL_W-1:0] o_first_analog_value,
  output logic                     o_second_observe_pin,
  output logic                     o_second_observe_pin_oe_n,
  output logic      [1:0]          o_second_observe_kind,
  output logic      [SAMPLE_W+LEVEL_W-1:0] o_second_analog_value,
  output logic      [LEVEL_W-1:0]  o_test_level_one_value,
  output logic      [LEVEL_W-1:0]  o_test_level_two_value
);
  localparam int unsigned AV_W = SAMPLE_W + LEVEL_W;

  logic [7:0]         src_sel_ff;
  logic [LEVEL_W-1:0] level_one_ff;
  logic [LEVEL_W-1:0] level_two_ff;
  logic [2:0]         obs_bit_sel_ff;
  logic               wr_pend_ff;
  logic [7:0]         wr_idx_ff;
  logic               rd_pend_ff;
  logic [7:0]         rd_idx_ff;
  logic [31:0]        hrdata_ff;
  logic               nxt_acc;
  logic [7:0]         acc_idx;
  logic               idx_ok;
  logic [7:0]         rd_byte;

  assign nxt_acc = hsel && hready && (htrans == atos_pkg::HTRANS_NONSEQ
                                      || htrans == atos_pkg::HTRANS_SEQ);
  // Upper address bits must be zero so aliases are not mapped
  assign acc_idx = haddr[9:2];
  assign idx_ok  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

  // Zero wait states; writes land at the end of the data phase
  assign hreadyout = 1'b1;
  assign hresp     = atos_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
      rd_pend_ff <= 1'b0;
      rd_idx_ff  <= 8'h00;
    end else begin
      wr_pend_ff <= nxt_acc && hwrite && idx_ok;
      rd_pend_ff <= nxt_acc && !hwrite && idx_ok;
      wr_idx_ff  <= acc_idx;
      rd_idx_ff  <= acc_idx;
    end
  end

  // Source select register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      src_sel_ff <= atos_pkg::RST_SRC_SEL; // [RQ1]
    end else if (wr_pend_ff && wr_idx_ff == atos_pkg::IDX_SRC_SEL) begin
      src_sel_ff <= hwdata[7:0];
    end
  end

  // Only the low six bits are storage; reserved bits never hold anything
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      level_one_ff <= LEVEL_W'(atos_pkg::RST_LEVEL);
      level_two_ff <= LEVEL_W'(atos_pkg::RST_LEVEL);
    end else if (wr_pend_ff) begin
      if (wr_idx_ff == atos_pkg::IDX_LEVEL_ONE) begin
        level_one_ff <= hwdata[LEVEL_W-1:0]; // [RQ13] [RQ18]
      end
      if (wr_idx_ff == atos_pkg::IDX_LEVEL_TWO) begin
        level_two_ff <= hwdata[LEVEL_W-1:0]; // [RQ14] [RQ18]
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      obs_bit_sel_ff <= atos_pkg::RST_OBS_SEL;
    end else if (wr_pend_ff && wr_idx_ff == atos_pkg::IDX_OBS_SEL) begin
      obs_bit_sel_ff <= hwdata[2:0]; // [RQ11]
    end
  end

  // Read mux; factory slots are constants so writes cannot touch them
  always_comb begin
    unique case (acc_idx)
      atos_pkg::IDX_SRC_SEL:   rd_byte = src_sel_ff;
      atos_pkg::IDX_LEVEL_ONE: rd_byte = 8'(level_one_ff);
      atos_pkg::IDX_LEVEL_TWO: rd_byte = 8'(level_two_ff);
      atos_pkg::IDX_IQ_READ:   rd_byte = {i_adc_i_sample[3:0], i_adc_q_sample[3:0]}; // [RQ15]
      atos_pkg::IDX_FACT_A:    rd_byte = atos_pkg::RST_FACT_A; // [RQ16] [RQ18]
      atos_pkg::IDX_FACT_B:    rd_byte = atos_pkg::RST_FACT_B; // [RQ17] [RQ18]
      atos_pkg::IDX_FACT_C:    rd_byte = atos_pkg::RST_FACT_C; // [RQ17] [RQ18]
      atos_pkg::IDX_FACT_D:    rd_byte = atos_pkg::RST_FACT_D; // [RQ17] [RQ18]
      atos_pkg::IDX_OBS_SEL:   rd_byte = {5'h00, obs_bit_sel_ff};
      default:                 rd_byte = 8'h00;
    endcase
  end

  // Sampled at the address phase so data is stable during the data phase
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hrdata_ff <= 32'h00000000;
    end else if (nxt_acc && !hwrite) begin
      hrdata_ff <= idx_ok ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Shared code table for both pins
  function automatic logic [AV_W+3:0] pick_source(
    input logic [3:0]         code,
    input logic [LEVEL_W-1:0] level
  );
    logic [1:0]      kind;
    logic            bit_v;
    logic [AV_W-1:0] av;
    kind  = atos_pkg::ATOS_KIND_DIGITAL;
    bit_v = 1'b0;
    av    = '0;
    unique case (code)
      atos_pkg::SRC_HIZ: kind = atos_pkg::ATOS_KIND_HIZ; // [RQ2]
      atos_pkg::SRC_LEVEL: begin
        kind = atos_pkg::ATOS_KIND_ANALOG; // [RQ3]
        av   = AV_W'(level);
      end
      atos_pkg::SRC_CORR_ONE: bit_v = i_correlator_one_signal; // [RQ4]
      atos_pkg::SRC_MIN_LEVEL: begin
        kind  = atos_pkg::ATOS_KIND_ANALOG; // [RQ4]
        bit_v = i_minimum_level_signal;
      end
      atos_pkg::SRC_ADC_I: begin
        kind = atos_pkg::ATOS_KIND_ANALOG; // [RQ5]
        av   = AV_W'(i_adc_i_sample);
      end
      atos_pkg::SRC_ADC_Q: begin
        kind = atos_pkg::ATOS_KIND_ANALOG; // [RQ5]
        av   = AV_W'(i_adc_q_sample);
      end
      atos_pkg::SRC_PROD: bit_v = i_production_test_signal; // [RQ6]
      atos_pkg::SRC_HIGH: bit_v = 1'b1; // [RQ7]
      atos_pkg::SRC_LOW: bit_v = 1'b0; // [RQ7]
      atos_pkg::SRC_TX_ACT: bit_v = i_transmit_activity_flag; // [RQ8]
      atos_pkg::SRC_RX_ACT: bit_v = i_receive_activity_flag; // [RQ9]
      atos_pkg::SRC_SUBC: bit_v = i_subcarrier_flag; // [RQ10]
      atos_pkg::SRC_TEST_BIT: bit_v = i_test_bus[obs_bit_sel_ff]; // [RQ11]
      // Reserved codes stay off the pin
      default: kind = atos_pkg::ATOS_KIND_HIZ; // [RQ6]
    endcase
    return {kind, bit_v, 1'b0, av};
  endfunction

  logic [AV_W+3:0] first_pick;
  logic [AV_W+3:0] second_pick;
  // A process, not an assign: the function reads the source inputs directly
  always_comb begin
    first_pick  = pick_source(src_sel_ff[atos_pkg::SEL1_LSB +: 4], level_one_ff); // [RQ2]
    second_pick = pick_source(src_sel_ff[atos_pkg::SEL2_LSB +: 4], level_two_ff); // [RQ12]
  end

  // Outputs registered so pins do not glitch while the selector changes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_first_observe_kind      <= atos_pkg::ATOS_KIND_HIZ;
      o_first_observe_pin       <= 1'b0;
      o_first_observe_pin_oe_n  <= 1'b1;
      o_first_analog_value      <= '0;
      o_second_observe_kind     <= atos_pkg::ATOS_KIND_HIZ;
      o_second_observe_pin      <= 1'b0;
      o_second_observe_pin_oe_n <= 1'b1;
      o_second_analog_value     <= '0;
    end else begin
      o_first_observe_kind      <= first_pick[AV_W+3:AV_W+2];
      o_first_observe_pin       <= first_pick[AV_W+1];
      o_first_observe_pin_oe_n  <= first_pick[AV_W+3:AV_W+2] != atos_pkg::ATOS_KIND_DIGITAL;
      o_first_analog_value      <= first_pick[AV_W-1:0];
      o_second_observe_kind     <= second_pick[AV_W+3:AV_W+2];
      o_second_observe_pin      <= second_pick[AV_W+1];
      o_second_observe_pin_oe_n <= second_pick[AV_W+3:AV_W+2] != atos_pkg::ATOS_KIND_DIGITAL;
      o_second_analog_value     <= second_pick[AV_W-1:0];
    end
  end

  assign o_test_level_one_value = level_one_ff;
  assign o_test_level_two_value = level_two_ff;

  a_reset_hiz: assert property (@(posedge i_sys_clk) // [RQ1]
    i_rst |=> (o_first_observe_pin_oe_n && o_second_observe_pin_oe_n))
    else $error("pins not high impedance after reset");

  a_high_code: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ7]
    (src_sel_ff[7:4] == atos_pkg::SRC_HIGH) |=> (o_first_observe_pin && !o_first_observe_pin_oe_n))
    else $error("high code does not drive high");

  a_low_code: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ7]
    (src_sel_ff[3:0] == atos_pkg::SRC_LOW) |=> (!o_second_observe_pin && !o_second_observe_pin_oe_n))
    else $error("low code does not drive low");

  a_tx_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ8]
    (src_sel_ff[7:4] == atos_pkg::SRC_TX_ACT) |=> (o_first_observe_pin == $past(i_transmit_activity_flag)))
    else $error("transmit flag not routed");

  a_rx_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ9]
    (src_sel_ff[3:0] == atos_pkg::SRC_RX_ACT) |=> (o_second_observe_pin == $past(i_receive_activity_flag)))
    else $error("receive flag not routed");

  a_reserved_off: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ6]
    (src_sel_ff[7:4] == 4'h3 || src_sel_ff[7:4] == 4'h7 || src_sel_ff[7:4] == 4'h9)
      |=> o_first_observe_pin_oe_n)
    else $error("reserved code drives a pin");

  a_level_route: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ3]
    (src_sel_ff[3:0] == atos_pkg::SRC_LEVEL) |=> (o_second_analog_value == AV_W'($past(level_two_ff))))
    else $error("level two not routed");

  sequence s_fact_read;
    nxt_acc && !hwrite && idx_ok && acc_idx == atos_pkg::IDX_FACT_A;
  endsequence
  a_factory_const: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ16]
    s_fact_read |=> (hrdata[7:0] == atos_pkg::RST_FACT_A))
    else $error("factory slot changed");

  a_test_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ11]
    (src_sel_ff[7:4] == atos_pkg::SRC_TEST_BIT)
      |=> (o_first_observe_pin == $past(i_test_bus[obs_bit_sel_ff])))
    else $error("test bus bit not routed");

  sequence s_wr_take(logic [7:0] idx);
    nxt_acc && hwrite && idx_ok && acc_idx == idx;
  endsequence
  sequence s_rd_take(logic [7:0] idx);
    nxt_acc && !hwrite && idx_ok && acc_idx == idx;
  endsequence
  sequence s_wr_land(logic [7:0] idx);
    wr_pend_ff && wr_idx_ff == idx;
  endsequence

  a_src_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ2]
    s_wr_land(atos_pkg::IDX_SRC_SEL)
      |=> (src_sel_ff == $past(hwdata[7:0])))
    else $error("source select write lost");

  a_level_one_wr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ13]
    s_wr_land(atos_pkg::IDX_LEVEL_ONE)
      |=> (level_one_ff == $past(hwdata[LEVEL_W-1:0])))
    else $error("level one write lost");

  a_level_two_wr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ14]
    s_wr_land(atos_pkg::IDX_LEVEL_TWO)
      |=> (level_two_ff == $past(hwdata[LEVEL_W-1:0])))
    else $error("level two write lost");

  a_obs_sel_wr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ11]
    s_wr_land(atos_pkg::IDX_OBS_SEL)
      |=> (obs_bit_sel_ff == $past(hwdata[2:0])))
    else $error("bit select write lost");

  a_sel_to_pin: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ2]
    (s_wr_take(atos_pkg::IDX_SRC_SEL) ##1 (hwdata[7:4] == atos_pkg::SRC_HIGH))
      |=> ##1 (o_first_observe_pin && !o_first_observe_pin_oe_n))
    else $error("written high code not on first pin");

  a_fact_b_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ17]
    s_rd_take(atos_pkg::IDX_FACT_B)
      |=> (hrdata == {24'h000000, atos_pkg::RST_FACT_B}))
    else $error("factory slot b changed");

  a_fact_c_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ17]
    s_rd_take(atos_pkg::IDX_FACT_C)
      |=> (hrdata == {24'h000000, atos_pkg::RST_FACT_C}))
    else $error("factory slot c changed");

  a_iq_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ15]
    s_rd_take(atos_pkg::IDX_IQ_READ)
      |=> (hrdata[7:0] == $past({i_adc_i_sample[3:0], i_adc_q_sample[3:0]})))
    else $error("sample readback wrong");

  a_rsvd_bits: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ18]
    s_rd_take(atos_pkg::IDX_LEVEL_ONE)
      |=> (hrdata[31:LEVEL_W] == '0))
    else $error("reserved level bits not zero");

  a_unmapped_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ18]
    (nxt_acc && !hwrite && (!idx_ok || acc_idx > atos_pkg::IDX_OBS_SEL))
      |=> (hrdata == 32'h00000000))
    else $error("unmapped read not zero");

  a_hiz_first: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ2]
    (src_sel_ff[7:4] == atos_pkg::SRC_HIZ)
      |=> (o_first_observe_pin_oe_n && o_first_observe_kind == atos_pkg::ATOS_KIND_HIZ))
    else $error("first pin not high impedance");

  a_hiz_second: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ12]
    (src_sel_ff[3:0] == atos_pkg::SRC_HIZ)
      |=> (o_second_observe_pin_oe_n && o_second_observe_kind == atos_pkg::ATOS_KIND_HIZ))
    else $error("second pin not high impedance");

  a_level_one_route: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ3]
    (src_sel_ff[7:4] == atos_pkg::SRC_LEVEL)
      |=> (o_first_analog_value == AV_W'($past(level_one_ff)) && o_first_observe_pin_oe_n))
    else $error("level one not routed");

  a_corr_route: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ4]
    (src_sel_ff[7:4] == atos_pkg::SRC_CORR_ONE)
      |=> (o_first_observe_pin == $past(i_correlator_one_signal) && !o_first_observe_pin_oe_n))
    else $error("correlator signal not routed");

  a_min_level: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ4]
    (src_sel_ff[3:0] == atos_pkg::SRC_MIN_LEVEL)
      |=> (o_second_observe_kind == atos_pkg::ATOS_KIND_ANALOG && o_second_observe_pin_oe_n))
    else $error("minimum level source not analogue");

  a_adc_i_route: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ5]
    (src_sel_ff[7:4] == atos_pkg::SRC_ADC_I)
      |=> (o_first_analog_value == AV_W'($past(i_adc_i_sample))))
    else $error("in-phase sample not routed");

  a_adc_q_route: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ5]
    (src_sel_ff[3:0] == atos_pkg::SRC_ADC_Q)
      |=> (o_second_analog_value == AV_W'($past(i_adc_q_sample))))
    else $error("quadrature sample not routed");

  a_prod_route: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ6]
    (src_sel_ff[7:4] == atos_pkg::SRC_PROD)
      |=> (o_first_observe_pin == $past(i_production_test_signal) && !o_first_observe_pin_oe_n))
    else $error("production signal not routed");

  a_subc_route: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ10]
    (src_sel_ff[3:0] == atos_pkg::SRC_SUBC)
      |=> (o_second_observe_pin == $past(i_subcarrier_flag) && !o_second_observe_pin_oe_n))
    else $error("subcarrier flag not routed");

  a_second_test_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RQ11]
    (src_sel_ff[3:0] == atos_pkg::SRC_TEST_BIT)
      |=> (o_second_observe_pin == $past(i_test_bus[obs_bit_sel_ff])))
    else $error("test bus bit not on second pin");
endmodule

// >>> testbench.sv
// Self-checking bench for the auxiliary test output select block.
// Assumes atos_pkg and atos_top are compiled first; one AHB-Lite master, no wait states expected.
`timescale 1ns/1ps
module testbench;
  logic        i_sys_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic        inv       = 1'b0;
  logic [7:0]  tbus;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic        p1, p1_oe_n, p2, p2_oe_n;
  logic [1:0]  k1, k2;
  logic [9:0]  a1, a2;
  logic [5:0]  lv1, lv2;
  logic [31:0] rd;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #4 i_sys_clk = ~i_sys_clk;
  assign hready = hreadyout;
  assign tbus   = inv ? 8'h5A : 8'hA5;

  atos_top atos_top_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .i_correlator_one_signal(~inv), .i_minimum_level_signal(inv),
    .i_production_test_signal(inv), .i_transmit_activity_flag(~inv),
    .i_receive_activity_flag(inv), .i_subcarrier_flag(~inv), .i_test_bus(tbus),
    .i_adc_i_sample(inv ? 4'h3 : 4'h9), .i_adc_q_sample(inv ? 4'hC : 4'h6),
    .o_first_observe_pin(p1), .o_first_observe_pin_oe_n(p1_oe_n), .o_first_observe_kind(k1),
    .o_first_analog_value(a1), .o_second_observe_pin(p2), .o_second_observe_pin_oe_n(p2_oe_n),
    .o_second_observe_kind(k2), .o_second_analog_value(a2),
    .o_test_level_one_value(lv1), .o_test_level_two_value(lv2));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Holds address phase, then data phase, each until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    haddr  <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= atos_pkg::HTRANS_NONSEQ;
    do @(posedge i_sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Idle cycle after a write so a following read sees the new value
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
    @(posedge i_sys_clk);
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk_reg(rd, exp);
    chk_reg({30'h0, hresp}, {30'h0, atos_pkg::HRESP_OKAY});
  endtask

  // Pin value is compared when driven digitally or for minimum level code 0100, analogue value only for analogue kinds
  task automatic chk_obs(input logic [3:0] c, input logic [9:0] lv, input logic oe_n,
                         input logic [1:0] k, input logic p, input logic [9:0] a);
    logic       d;
    logic [1:0] ek;
    logic [9:0] ea;
    ek = 2'h1;
    d  = 1'b0;
    ea = 10'h000;
    case (c)
      4'h1: begin ek = 2'h2; ea = lv; end
      4'h4: begin ek = 2'h2; d = inv; end
      4'h5: begin ek = 2'h2; ea = inv ? 10'h003 : 10'h009; end
      4'h6: begin ek = 2'h2; ea = inv ? 10'h00C : 10'h006; end
      4'h2, 4'hC, 4'hE, 4'hF: d = ~inv;
      4'h8, 4'hD: d = inv;
      4'hA: d = 1'b1;
      4'hB: d = 1'b0;
      default: ek = 2'h0;
    endcase
    samples_checked++;
    if ({oe_n, k, (ek == 2'h1 || c == 4'h4) ? p : 1'b0, (ek != 2'h2) ? 10'h000 : a}
        !== {ek != 2'h1, ek, d, ea}) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, {oe_n, k, p, a}, {ek != 2'h1, ek, d, ea});
    end
  endtask

  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk_reg({30'h0, p1_oe_n, p2_oe_n}, 32'h0000_0003);
    chk_reg({28'h0, k1, k2}, 32'h0000_0000);
    @(posedge i_sys_clk);
    rd_chk(8'h38, 32'h0000_0000);
    rd_chk(8'h3C, 32'h0000_00FF);
    rd_chk(8'h3D, 32'h0000_0000);
    rd_chk(8'h3E, 32'h0000_0003);
    rd_chk(8'h3F, 32'h0000_0000);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h3C + i[7:0], 32'h0000_005A);
    end
    rd_chk(8'h3C, 32'h0000_00FF);
    rd_chk(8'h3D, 32'h0000_0000);
    rd_chk(8'h3E, 32'h0000_0003);
    rd_chk(8'h3F, 32'h0000_0000);
    wr(8'h3B, 32'h0000_00FF);
    rd_chk(8'h3B, 32'h0000_0096);
    rd_chk(8'h50, 32'h0000_0000);
    $display("test reserved and readback done");
    wr(8'h39, 32'h0000_00EA);
    wr(8'h3A, 32'h0000_00D5);
    rd_chk(8'h39, 32'h0000_002A);
    rd_chk(8'h3A, 32'h0000_0015);
    chk_reg({26'h0, lv1}, 32'h0000_002A);
    chk_reg({26'h0, lv2}, 32'h0000_0015);
    wr(8'h40, 32'h0000_0005);
    $display("test level registers done");
    for (int ph = 0; ph < 2; ph++) begin
      inv <= ph[0];
      for (int c = 0; c < 16; c++) begin
        wr(8'h38, {24'h0, c[3:0], ~c[3:0]});
        rd_chk(8'h38, {24'h0, c[3:0], ~c[3:0]});
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk_obs(c[3:0], 10'h02A, p1_oe_n, k1, p1, a1);
        chk_obs(~c[3:0], 10'h015, p2_oe_n, k2, p2, a2);
        @(posedge i_sys_clk);
      end
    end
    rd_chk(8'h3B, 32'h0000_003C);
    $display("test source codes done");
    complete_run();
  end
endmodule
